// File: bench/rrex_exec_chk.sv
/*
  Checker for the return and rotate slice: phase walk, strobe timing,
  stack pop pairing and the idle cycle after a return.
  Assumes it is bound to rrex_exec and sees that module's ports only.
*/
module rrex_exec_chk (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_b_in,
  // Watched signals
  input wire logic [3:0] q_phase_out,
  input wire logic flush_out,
  input wire logic pc_load_out,
  input wire logic stack_pop_out,
  input wire logic [12:0] pc_out,
  input wire logic [12:0] stack_top_in,
  input wire logic acc_we_out,
  input wire logic file_we_out,
  input wire logic carry_we_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);
  // Phase walk that follows every Q1
  sequence s_q2_to_q4;
    q_phase_out == 4'h2 ##1 q_phase_out == 4'h4 ##1 q_phase_out == 4'h8;
  endsequence
  // Whole idle cycle after a pop, then back to work
  sequence s_idle_cycle;
    flush_out [*4] ##1 !flush_out;
  endsequence
  a_phase_walk: assert property (q_phase_out == 4'h1 |=> s_q2_to_q4)
    else $error("quarter phase order broken");
  a_ret_idle: assert property (pc_load_out |=> s_idle_cycle)
    else $error("return idle cycle wrong");
  a_pop_pairs: assert property (pc_load_out |-> stack_pop_out)
    else $error("pc load without pop");
  a_pop_only_ret: assert property (stack_pop_out |-> pc_load_out)
    else $error("pop without pc load");
  a_pc_from_top: assert property (
    pc_load_out |-> pc_out == $past(stack_top_in))
    else $error("pc not from stack top");
  a_write_q4: assert property (
    (acc_we_out || file_we_out || carry_we_out) |-> q_phase_out == 4'h8)
    else $error("write outside Q4");
  a_one_dest: assert property (
    carry_we_out |-> acc_we_out != file_we_out)
    else $error("rotate destination wrong");
  a_ret_flags: assert property (
    pc_load_out |-> !carry_we_out && !file_we_out)
    else $error("return touched flags");
  a_idle_quiet: assert property (
    flush_out |-> !(pc_load_out || acc_we_out || file_we_out))
    else $error("activity in idle cycle");
endmodule

bind rrex_exec rrex_exec_chk u_chk (
  .clock_in(clock_in),
  .rst_b_in(rst_b_in),
  .q_phase_out(q_phase_out),
  .flush_out(flush_out),
  .pc_load_out(pc_load_out),
  .stack_pop_out(stack_pop_out),
  .pc_out(pc_out),
  .stack_top_in(stack_top_in),
  .acc_we_out(acc_we_out),
  .file_we_out(file_we_out),
  .carry_we_out(carry_we_out)
);

// File: bench/test_return_and_rotate_exec.sv
/*
  Self-checking bench for the return and rotate slice.
  Assumes the design sources and the checker are compiled first.
*/
module test_return_and_rotate_exec;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic instr_valid_in = 1'b0;
  logic [13:0] instr_in = 14'h0000;
  logic [12:0] stack_top_in = 13'h0000;
  logic [7:0] file_rd_data_in = 8'h00;
  logic carry_in = 1'b0;
  logic [3:0] q_phase_out;
  logic claim_out, flush_out, pc_load_out, stack_pop_out;
  logic acc_we_out, file_we_out, carry_we_out, carry_out;
  logic [12:0] pc_out;
  logic [7:0] acc_data_out, file_wr_data_out;
  logic [6:0] file_addr_out;
  integer failures = 0;
  integer cmp_count = 0;

  rrex_exec DUT (
    .clock_in(clock_in),
    .rst_b_in(rst_b_in),
    .instr_valid_in(instr_valid_in),
    .instr_in(instr_in),
    .q_phase_out(q_phase_out),
    .claim_out(claim_out),
    .flush_out(flush_out),
    .stack_top_in(stack_top_in),
    .pc_load_out(pc_load_out),
    .pc_out(pc_out),
    .stack_pop_out(stack_pop_out),
    .acc_we_out(acc_we_out),
    .acc_data_out(acc_data_out),
    .file_addr_out(file_addr_out),
    .file_rd_data_in(file_rd_data_in),
    .file_we_out(file_we_out),
    .file_wr_data_out(file_wr_data_out),
    .carry_in(carry_in),
    .carry_we_out(carry_we_out),
    .carry_out(carry_out)
  );

  // Free running core clock
  initial begin
    forever #5 clock_in = ~clock_in;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic final_report;
    $display("Compares %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Word goes in at the next Q1; returns settled inside its Q4
  task automatic exec(input logic [13:0] w, input logic [7:0] fd,
                      input logic c, input logic [12:0] st);
    int n = 0;
    while (q_phase_out !== 4'h8) begin
      @(posedge clock_in);
      #1;
      n++;
      if (n > 8) begin
        failures++;
        $display("Error at %0t: phase wait timed out", $time);
        final_report();
      end
    end
    @(posedge clock_in);
    instr_in <= w;
    instr_valid_in <= 1'b1;
    file_rd_data_in <= fd;
    carry_in <= c;
    stack_top_in <= st;
    @(posedge clock_in);
    instr_valid_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    #1;
  endtask

  // Outputs quiet and phase parked in Q1 while reset is held
  task automatic t_reset;
    chk({claim_out, flush_out, pc_load_out, stack_pop_out, acc_we_out,
         file_we_out, carry_we_out, carry_out}, 0);
    chk(q_phase_out, 16'h0001);
    $display("reset test done");
  endtask

  // Literal return, then a word dropped into its idle cycle
  task automatic t_ret_lit;
    exec(14'h3755, 8'h00, 1'b0, 13'h1abc);
    chk({pc_load_out, stack_pop_out, acc_we_out, file_we_out,
         carry_we_out}, 16'h001c);
    chk(acc_data_out, 16'h0055);
    chk(pc_out, 16'h1abc);
    exec(14'h0d85, 8'h0f, 1'b1, 13'h0000);
    chk(flush_out, 16'h0001);
    chk({claim_out, pc_load_out, acc_we_out, file_we_out,
         carry_we_out}, 0);
    $display("literal return test done");
  endtask

  // Plain return leaves the accumulator and carry alone
  task automatic t_ret;
    exec(14'h0008, 8'h00, 1'b0, 13'h0123);
    chk({pc_load_out, stack_pop_out, acc_we_out, file_we_out,
         carry_we_out}, 16'h0018);
    chk(pc_out, 16'h0123);
    chk(acc_data_out, 16'h0055);
    // Sit out the idle cycle so the next word is not dropped
    repeat (4) @(posedge clock_in);
    #1;
    chk(flush_out, 16'h0001);
    $display("plain return test done");
  endtask

  // Rotate through carry, issued back to back
  task automatic t_rot(input logic [13:0] w, input logic [7:0] fd,
                       input logic c);
    logic l;
    logic [7:0] r;
    l = (w[13:8] == 6'h0d);
    r = l ? {fd[6:0], c} : {c, fd[7:1]};
    exec(w, fd, c, 13'h0000);
    chk(file_addr_out, w[6:0]);
    chk({pc_load_out, flush_out, acc_we_out, file_we_out, carry_we_out},
        {2'b00, ~w[7], w[7], 1'b1});
    chk(w[7] ? file_wr_data_out : acc_data_out, r);
    chk(carry_out, l ? fd[7] : fd[0]);
    chk(claim_out, 16'h0001);
    $display("rotate test done");
  endtask

  // Word outside the four is ignored and results hold
  task automatic t_other;
    exec(14'h0e55, 8'h5a, 1'b1, 13'h0fff);
    chk({claim_out, pc_load_out, stack_pop_out, acc_we_out, file_we_out,
         carry_we_out, flush_out}, 0);
    chk(acc_data_out, 16'h0003);
    chk(pc_out, 16'h0123);
    $display("other word test done");
  endtask

  // Main sequence
  initial begin
    repeat (12) @(posedge clock_in);
    t_reset();
    rst_b_in <= 1'b1;
    t_ret_lit();
    t_ret();
    t_rot(14'h0d85, 8'he6, 1'b0);
    t_rot(14'h0c7f, 8'he6, 1'b1);
    t_rot(14'h0d20, 8'h81, 1'b1);
    t_other();
    final_report();
  end
endmodule

// File: src/rrex_exec.v
/*
  Execution slice for four instructions of an 8-bit core with 14-bit
  words: return with literal, plain return, rotate left and rotate right
  through carry. Holds its own quarter phase sequencer.
  Assumes the core presents the instruction word in Q1, returns file
  data combinationally from file_addr_out, and keeps stack storage,
  the accumulator, carry and the register file outside. All inputs are
  on clock_in; none needs synchronising.
*/
`include "rrex_regs.vh"

// Operation
// (RL1) Literal return puts the 8-bit literal in the accumulator; no flags.
// (RL2) Return with literal loads the program counter from the stack top.
// (RL3) Return with literal is a single word taking two instruction cycles.
// (RL4) Decode Q1, literal Q2, idle Q3, write and pop Q4; second cycle idle.
// (RL5) Rotate left through carry; result to accumulator or file; one cycle.
// (RL6) Rotate right through carry; result to accumulator or file; one cycle.
// (RL7) A return pops the stack top into the program counter.
// (RL8) Plain return pops in Q4, affects no flags, adds one idle cycle.
module rrex_exec (
  // Clock and reset
  input wire clock_in,
  input wire rst_b_in,
  // Instruction and phase
  input wire instr_valid_in,
  input wire [`RREX_IW-1:0] instr_in,
  output wire [3:0] q_phase_out,
  output wire claim_out,
  output wire flush_out,
  // Program counter and stack
  input wire [`RREX_PCW-1:0] stack_top_in,
  output wire pc_load_out,
  output wire [`RREX_PCW-1:0] pc_out,
  output wire stack_pop_out,
  // Accumulator
  output wire acc_we_out,
  output wire [`RREX_DW-1:0] acc_data_out,
  // File register port
  output wire [`RREX_FAW-1:0] file_addr_out,
  input wire [`RREX_DW-1:0] file_rd_data_in,
  output wire file_we_out,
  output wire [`RREX_DW-1:0] file_wr_data_out,
  // Carry flag
  input wire carry_in,
  output wire carry_we_out,
  output wire carry_out
);

  // Classify one instruction word
  function [`RREX_OPW-1:0] rrex_decode;
    input [`RREX_IW-1:0] w;
    begin
      if (w[`RREX_OP_RETLIT_HI:`RREX_OP_RETLIT_LO] == `RREX_OP_RETLIT) begin
        rrex_decode = `RREX_DEC_RETLIT;
      end else if (w == `RREX_OP_RETURN) begin
        rrex_decode = `RREX_DEC_RET;
      end else if (w[`RREX_OP_ROT_HI:`RREX_OP_ROT_LO] == `RREX_OP_RLC) begin
        rrex_decode = `RREX_DEC_RLC;
      end else if (w[`RREX_OP_ROT_HI:`RREX_OP_ROT_LO] == `RREX_OP_RRC) begin
        rrex_decode = `RREX_DEC_RRC;
      end else begin
        rrex_decode = `RREX_DEC_NONE;
      end
    end
  endfunction

  wire [3:0] q;
  wire in_q1;
  wire in_q2;
  wire in_q3;
  wire in_q4;

  reg [`RREX_IW-1:0] instr_r;
  reg [`RREX_OPW-1:0] op_r;
  reg [`RREX_DW-1:0] operand_r;
  reg second_r;
  reg pc_load_r;
  reg [`RREX_PCW-1:0] pc_r;
  reg pop_r;
  reg acc_we_r;
  reg [`RREX_DW-1:0] acc_data_r;
  reg file_we_r;
  reg [`RREX_DW-1:0] file_wr_data_r;
  reg carry_we_r;
  reg carry_r;

  // Next values from the combinational processes below
  reg [`RREX_OPW-1:0] op_nxt;
  reg [`RREX_DW-1:0] rot_nxt;
  reg carry_nxt;

  // is_return is shared by both returns for pop, pc load and the idle cycle; dest_file picks the rotate target
  wire is_return;
  wire dest_file;

  // Phase sequencer
  rrex_qphase u_qphase (
    .clock_in(clock_in),
    .rst_b_in(rst_b_in),
    .q_out(q)
  );

  assign in_q1 = q[`RREX_PH_IDX_Q1];
  assign in_q2 = q[`RREX_PH_IDX_Q2];
  assign in_q3 = q[`RREX_PH_IDX_Q3];
  assign in_q4 = q[`RREX_PH_IDX_Q4];

  assign is_return = op_r[`RREX_DI_RETLIT] | op_r[`RREX_DI_RET];
  assign dest_file = instr_r[`RREX_DEST_BIT];

  // Decode in Q1; a word offered in the idle cycle is not taken
  always @* begin
    if (instr_valid_in && !second_r) begin
      op_nxt = rrex_decode(instr_in); // RL4
    end else begin
      op_nxt = `RREX_DEC_NONE;
    end
  end

  // Rotate through carry, using the operand read in Q2.
  // Carry is taken at the Q3 edge, so a write by the previous word is seen.
  always @* begin
    rot_nxt = operand_r;
    carry_nxt = carry_in;
    if (op_r[`RREX_DI_RLC]) begin
      rot_nxt = {operand_r[`RREX_DW-2:0], carry_in}; // RL5
      carry_nxt = operand_r[`RREX_DW-1]; // RL5
    end else if (op_r[`RREX_DI_RRC]) begin
      rot_nxt = {carry_in, operand_r[`RREX_DW-1:1]}; // RL6
      carry_nxt = operand_r[0]; // RL6
    end
  end

  // Instruction capture and operand read
  always @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      instr_r <= `RREX_RST_IW;
      op_r <= `RREX_DEC_NONE;
      operand_r <= `RREX_RST_DW;
    end else begin
      if (in_q1) begin
        instr_r <= instr_in;
        op_r <= op_nxt;
      end
      if (in_q2) begin
        if (op_r[`RREX_DI_RETLIT]) begin
          operand_r <= instr_r[`RREX_LIT_HI:`RREX_LIT_LO]; // RL4
        end else begin
          operand_r <= file_rd_data_in;
        end
      end
    end
  end

  // Results registered at the end of Q3 so strobes stand through Q4.
  // Q3 itself does nothing for returns, so the pop lands in Q4.
  always @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pc_load_r <= 1'b0;
      pc_r <= `RREX_RST_PC;
      pop_r <= 1'b0;
      acc_we_r <= 1'b0;
      acc_data_r <= `RREX_RST_DW;
      file_we_r <= 1'b0;
      file_wr_data_r <= `RREX_RST_DW;
      carry_we_r <= 1'b0;
      carry_r <= 1'b0;
    end else if (in_q3) begin
      pc_load_r <= is_return; // RL2
      pop_r <= is_return; // RL7
      if (is_return) begin
        pc_r <= stack_top_in; // RL7
      end
      // Literal to the accumulator; carry strobe stays low for returns
      acc_we_r <= op_r[`RREX_DI_RETLIT] |
                  ((op_r[`RREX_DI_RLC] | op_r[`RREX_DI_RRC]) & !dest_file);
      file_we_r <= (op_r[`RREX_DI_RLC] | op_r[`RREX_DI_RRC]) & dest_file;
      carry_we_r <= op_r[`RREX_DI_RLC] | op_r[`RREX_DI_RRC]; // RL8
      if (op_r[`RREX_DI_RETLIT]) begin
        acc_data_r <= operand_r; // RL1
      end else if (op_r[`RREX_DI_RLC] | op_r[`RREX_DI_RRC]) begin
        acc_data_r <= rot_nxt; // RL5
        file_wr_data_r <= rot_nxt; // RL6
        carry_r <= carry_nxt;
      end
    end else begin
      // Strobes last exactly the Q4 clock
      pc_load_r <= 1'b0;
      pop_r <= 1'b0;
      acc_we_r <= 1'b0;
      file_we_r <= 1'b0;
      carry_we_r <= 1'b0;
    end
  end

  // Idle second cycle for both returns; rotates never set it.
  // Cleared at the idle cycle's Q4, so idle cycles never chain.
  always @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      second_r <= 1'b0;
    end else if (in_q4) begin
      second_r <= is_return & !second_r; // RL3 RL8
    end
  end

  // Outputs
  assign q_phase_out = q;
  assign claim_out = op_r != `RREX_DEC_NONE;
  assign flush_out = second_r; // Core fetch is discarded this cycle
  assign pc_load_out = pc_load_r;
  assign pc_out = pc_r;
  assign stack_pop_out = pop_r;
  assign acc_we_out = acc_we_r;
  assign acc_data_out = acc_data_r;
  assign file_addr_out = instr_r[`RREX_FA_HI:`RREX_FA_LO];
  assign file_we_out = file_we_r;
  assign file_wr_data_out = file_wr_data_r;
  assign carry_we_out = carry_we_r;
  assign carry_out = carry_r;

endmodule

// File: src/rrex_qphase.v
/*
  Quarter phase sequencer: one-hot Q1..Q4, advancing every clock.
  Assumes one clock, clock_in, and an asynchronous active-low reset.
*/
`include "rrex_regs.vh"

module rrex_qphase (
  // Clock and reset
  input wire clock_in,
  input wire rst_b_in,
  // Phase
  output wire [3:0] q_out
);

  localparam [3:0] Q1 = `RREX_PH_Q1;
  localparam [3:0] Q2 = `RREX_PH_Q2;
  localparam [3:0] Q3 = `RREX_PH_Q3;
  localparam [3:0] Q4 = `RREX_PH_Q4;

  reg [3:0] q_r;
  reg [3:0] q_nxt;

  // Next phase
  always @* begin
    case (q_r)
      Q1: q_nxt = Q2;
      Q2: q_nxt = Q3;
      Q3: q_nxt = Q4;
      Q4: q_nxt = Q1;
      default: q_nxt = Q1; // Recovers from a corrupted code
    endcase
  end

  // Phase register, starts in Q1 after reset
  always @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      q_r <= Q1;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign q_out = q_r;

endmodule

// File: src/rrex_regs.vh
/*
  Constants for the return and rotate execution slice of the core:
  opcode patterns, field positions, widths, phase codes and reset values.
  Assumes it is included by bare name from each design file under src/.
*/
`ifndef RREX_REGS_VH
`define RREX_REGS_VH

// Widths
`define RREX_IW 14
`define RREX_DW 8
`define RREX_PCW 13
`define RREX_FAW 7

// Quarter phases, one-hot
`define RREX_PH_Q1 4'h1
`define RREX_PH_Q2 4'h2
`define RREX_PH_Q3 4'h4
`define RREX_PH_Q4 4'h8
`define RREX_PH_IDX_Q1 0
`define RREX_PH_IDX_Q2 1
`define RREX_PH_IDX_Q3 2
`define RREX_PH_IDX_Q4 3

// Opcode patterns
`define RREX_OP_RETLIT_HI 13
`define RREX_OP_RETLIT_LO 10
`define RREX_OP_RETLIT 4'hd
`define RREX_OP_ROT_HI 13
`define RREX_OP_ROT_LO 8
`define RREX_OP_RLC 6'h0d
`define RREX_OP_RRC 6'h0c
`define RREX_OP_RETURN 14'h0008

// Instruction fields
`define RREX_LIT_HI 7
`define RREX_LIT_LO 0
`define RREX_DEST_BIT 7
`define RREX_FA_HI 6
`define RREX_FA_LO 0

// Decoded operation, one-hot
`define RREX_OPW 4
`define RREX_DEC_NONE 4'h0
`define RREX_DEC_RETLIT 4'h1
`define RREX_DEC_RET 4'h2
`define RREX_DEC_RLC 4'h4
`define RREX_DEC_RRC 4'h8
`define RREX_DI_RETLIT 0
`define RREX_DI_RET 1
`define RREX_DI_RLC 2
`define RREX_DI_RRC 3

// Reset values
`define RREX_RST_IW 14'h0000
`define RREX_RST_DW 8'h00
`define RREX_RST_PC 13'h0000

`endif
